// >>> prox_map.vh
// Register map, field positions, reset values and timing counts for the proximity register bank
// Summary of operation
// - Power bit zero shuts down, one runs
// - Calibration enable bit seven, default off
// - Bit fourteen selects sixteen-bit wide result
// - Bit thirteen enables sun protect flag, which drives the pin except in level mode
// - Bit twelve enables adaptive persistence
// - Crossing count code gives one to four
// - Interrupt mode off, level, or per event
// - Sample interval 50 to 400 ms
// - Integration length 1,2,4,8 base pulses
// - Base pulse 25 or 50 us
// - Emitter pulses per sample 1,2,4,8
// - Bit thirteen selects high converter sensitivity
// - Bit twelve enables crosstalk cancellation
// - Emitter current code selects 7 to 20 mA
// - Mode select and forced measurement trigger
// - Nonzero fast interval overrides normal interval
// - Sun cancellation enable in third high byte
// - Low and high thresholds, default zero
// - Offset count subtracted from raw count
// - Result at 0xf8, low byte first
// - ID low byte follows selected address
// - Flags high byte at 0xf9, read only
// - Trigger clears itself after measurement
// - Flags: high 9, low 8, sun 12
// - Fast interval codes 6.25, 12.5, 25 ms
`ifndef PROX_MAP_VH
`define PROX_MAP_VH
`define PROX_CMD_CTRL_A 8'h00
`define PROX_CMD_CTRL_B 8'h01
`define PROX_CMD_CTRL_C 8'h02
`define PROX_CMD_LOW_LIMIT 8'h03
`define PROX_CMD_HIGH_LIMIT 8'h04
`define PROX_CMD_OFFSET 8'h05
`define PROX_CMD_RESULT 8'hf8
`define PROX_CMD_FLAGS 8'hf9
`define PROX_CMD_IDENT 8'hfa
`define PROX_RESET_WORD 16'h0000
`define PROX_ADDR_PRIMARY 7'h60
`define PROX_ADDR_SWAPPED 7'h51
`define PROX_IDENT_HIGH 8'h5a
`define PROX_IDENT_LOW_PRIMARY 8'h3c
`define PROX_IDENT_LOW_SWAPPED 8'h3d
`define PROX_BIT_POWER 0
`define PROX_BIT_CALIB 7
`define PROX_BIT_WIDE 14
`define PROX_BIT_SUN_IRQ 13
`define PROX_BIT_ADAPT 12
`define PROX_BIT_PERS_LO 10
`define PROX_BIT_MODE_LO 8
`define PROX_BIT_GAIN 0
`define PROX_BIT_BASE 1
`define PROX_BIT_PULSES_LO 2
`define PROX_BIT_INTEG_LO 4
`define PROX_BIT_INTERVAL_LO 6
`define PROX_BIT_CURRENT_LO 8
`define PROX_BIT_XTALK 12
`define PROX_BIT_SENS 13
`define PROX_BIT_FORCE_MODE 4
`define PROX_BIT_TRIGGER 5
`define PROX_BIT_SUN_CANCEL 10
`define PROX_BIT_FAST_LO 14
`define PROX_FLAG_LOW 8
`define PROX_FLAG_HIGH 9
`define PROX_FLAG_SUN 12
`define PROX_CLK_MHZ 250
`define PROX_BASE_INTERVAL_US 6250
`define PROX_BASE_PULSE_US 25
`endif

// >>> prox_regs.v
// Two-wire slave, register bank and measurement sequencer of the proximity sensor
`timescale 1ns/100ps
`include "prox_map.vh"
module prox_regs #(
  parameter INTERVAL_TICK = `PROX_BASE_INTERVAL_US * `PROX_CLK_MHZ,
  parameter PULSE_TICK = `PROX_BASE_PULSE_US * `PROX_CLK_MHZ
) (
  input wire clk,
  input wire rst,
  input wire pin5_in,
  output wire pin5_oe,
  input wire pin6_in,
  output wire pin6_oe,
  output wire irq_n_oe,
  input wire [15:0] raw_count,
  input wire sun_event,
  output reg sensor_power_on,
  output reg internal_calib_enable,
  output reg converter_gain_select,
  output reg converter_sensitivity_select,
  output reg crosstalk_cancel_enable,
  output reg [2:0] emitter_current_select,
  output reg sun_cancel_enable,
  output reg emitter_active
);
  reg [15:0] ctrl_a_reg, ctrl_b_reg, ctrl_c_reg, low_limit_reg, high_limit_reg, offset_reg, result_reg;
  reg [15:0] flags_reg;
  reg [1:0] p5_sync, p6_sync;
  reg p5_q, p6_q;
  reg swapped_reg, strap_done_reg;
  wire scl = swapped_reg ? p6_sync[1] : p5_sync[1];
  wire sda = swapped_reg ? p5_sync[1] : p6_sync[1];
  wire scl_q = swapped_reg ? p6_q : p5_q;
  wire sda_q = swapped_reg ? p5_q : p6_q;
  wire scl_rise = scl & ~scl_q;
  wire scl_fall = ~scl & scl_q;
  wire start_seen = scl & scl_q & sda_q & ~sda;
  wire stop_seen = scl & scl_q & ~sda_q & sda;
  wire [6:0] my_addr = swapped_reg ? `PROX_ADDR_SWAPPED : `PROX_ADDR_PRIMARY;
  wire [7:0] ident_low = swapped_reg ? `PROX_IDENT_LOW_SWAPPED : `PROX_IDENT_LOW_PRIMARY;

  localparam ST_IDLE = 6'b000001;
  localparam ST_ADDR = 6'b000010;
  localparam ST_ACK = 6'b000100;
  localparam ST_RX = 6'b001000;
  localparam ST_TX = 6'b010000;
  localparam ST_TXACK = 6'b100000;
  reg [5:0] st_reg;
  reg [7:0] shift_reg;
  reg [3:0] bit_reg;
  reg [7:0] cmd_reg;
  reg [1:0] byte_reg;
  reg read_reg, sda_drive_reg, nack_reg;
  reg [15:0] rd_word;

  always @* begin
    case (cmd_reg)
      `PROX_CMD_CTRL_A: rd_word = ctrl_a_reg;
      `PROX_CMD_CTRL_B: rd_word = ctrl_b_reg;
      `PROX_CMD_CTRL_C: rd_word = ctrl_c_reg;
      `PROX_CMD_LOW_LIMIT: rd_word = low_limit_reg;
      `PROX_CMD_HIGH_LIMIT: rd_word = high_limit_reg;
      `PROX_CMD_OFFSET: rd_word = offset_reg;
      `PROX_CMD_RESULT: rd_word = result_reg;
      `PROX_CMD_FLAGS: rd_word = flags_reg;
      `PROX_CMD_IDENT: rd_word = {`PROX_IDENT_HIGH, ident_low};
      default: rd_word = 16'h0000;
    endcase
  end

  wire meas_done;
  reg [15:0] wr_low_reg;
  reg wr_strobe;
  reg [15:0] wr_data;

  // Pins first pass two flops; the address strap is taken from the first pin edge after reset
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      p5_sync <= 2'b11;
      p6_sync <= 2'b11;
      p5_q <= 1'b1;
      p6_q <= 1'b1;
      swapped_reg <= 1'b0;
      strap_done_reg <= 1'b0;
    end else begin
      p5_sync <= {p5_sync[0], pin5_in};
      p6_sync <= {p6_sync[0], pin6_in};
      p5_q <= p5_sync[1];
      p6_q <= p6_sync[1];
      // First falling pin while the other is high is data of the first start
      if (!strap_done_reg && (p5_q != p5_sync[1] || p6_q != p6_sync[1])) begin
        strap_done_reg <= 1'b1;
        swapped_reg <= p5_q & ~p5_sync[1] & p6_sync[1];
      end
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg <= ST_IDLE;
      shift_reg <= 8'h00;
      bit_reg <= 4'h0;
      cmd_reg <= 8'h00;
      byte_reg <= 2'b00;
      read_reg <= 1'b0;
      sda_drive_reg <= 1'b0;
      nack_reg <= 1'b0;
      wr_low_reg <= 16'h0000;
      wr_strobe <= 1'b0;
      wr_data <= 16'h0000;
    end else begin
      wr_strobe <= 1'b0;
      if (!strap_done_reg) begin
        // The strap edge is the data fall of the first start, so the address phase opens here
        if (p5_q != p5_sync[1] || p6_q != p6_sync[1]) begin
          st_reg <= ST_ADDR;
          bit_reg <= 4'h0;
        end else begin
          st_reg <= ST_IDLE;
        end
      end else if (start_seen) begin
        // Repeated start keeps the command code for the read phase
        st_reg <= ST_ADDR;
        bit_reg <= 4'h0;
        sda_drive_reg <= 1'b0;
      end else if (stop_seen) begin
        st_reg <= ST_IDLE;
        sda_drive_reg <= 1'b0;
      end else begin
        case (st_reg)
          ST_IDLE: begin
            sda_drive_reg <= 1'b0;
          end
          ST_ADDR: begin
            if (scl_rise) begin
              shift_reg <= {shift_reg[6:0], sda};
              bit_reg <= bit_reg + 4'h1;
            end
            if (scl_fall && bit_reg == 4'h8) begin
              if (shift_reg[7:1] == my_addr) begin
                read_reg <= shift_reg[0];
                byte_reg <= 2'b00;
                sda_drive_reg <= 1'b1;
                st_reg <= ST_ACK;
              end else begin
                st_reg <= ST_IDLE;
              end
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              bit_reg <= 4'h0;
              if (read_reg) begin
                shift_reg <= (byte_reg == 2'b00) ? rd_word[7:0] : rd_word[15:8];
                sda_drive_reg <= ~((byte_reg == 2'b00) ? rd_word[7] : rd_word[15]);
                st_reg <= ST_TX;
              end else begin
                sda_drive_reg <= 1'b0;
                st_reg <= ST_RX;
              end
            end
          end
          ST_RX: begin
            if (scl_rise) begin
              shift_reg <= {shift_reg[6:0], sda};
              bit_reg <= bit_reg + 4'h1;
            end
            if (scl_fall && bit_reg == 4'h8) begin
              sda_drive_reg <= 1'b1;
              st_reg <= ST_ACK;
              // Command code, then low byte, then high byte
              if (byte_reg == 2'b00) begin
                cmd_reg <= shift_reg;
                byte_reg <= 2'b01;
              end else if (byte_reg == 2'b01) begin
                wr_low_reg <= {8'h00, shift_reg};
                byte_reg <= 2'b10;
              end else begin
                wr_data <= {shift_reg, wr_low_reg[7:0]};
                wr_strobe <= 1'b1;
                byte_reg <= 2'b00;
              end
            end
          end
          ST_TX: begin
            if (scl_fall) begin
              bit_reg <= bit_reg + 4'h1;
              shift_reg <= {shift_reg[6:0], 1'b0};
              if (bit_reg == 4'h7) begin
                sda_drive_reg <= 1'b0;
                st_reg <= ST_TXACK;
              end else begin
                sda_drive_reg <= ~shift_reg[6];
              end
            end
          end
          ST_TXACK: begin
            if (scl_rise) begin
              nack_reg <= sda;
            end
            if (scl_fall) begin
              if (nack_reg) begin
                st_reg <= ST_IDLE;
              end else begin
                byte_reg <= 2'b01;
                bit_reg <= 4'h0;
                shift_reg <= rd_word[15:8];
                sda_drive_reg <= ~rd_word[15];
                st_reg <= ST_TX;
              end
            end
          end
          default: st_reg <= ST_IDLE;
        endcase
      end
    end
  end

  assign pin5_oe = swapped_reg & sda_drive_reg;
  assign pin6_oe = ~swapped_reg & sda_drive_reg;

  // Register writes; read-only codes and unknown codes are ignored
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_a_reg <= `PROX_RESET_WORD;
      ctrl_b_reg <= `PROX_RESET_WORD;
      ctrl_c_reg <= `PROX_RESET_WORD;
      low_limit_reg <= `PROX_RESET_WORD;
      high_limit_reg <= `PROX_RESET_WORD;
      offset_reg <= `PROX_RESET_WORD;
    end else begin
      if (wr_strobe) begin
        case (cmd_reg)
          `PROX_CMD_CTRL_A: ctrl_a_reg <= wr_data;
          `PROX_CMD_CTRL_B: ctrl_b_reg <= wr_data;
          `PROX_CMD_CTRL_C: ctrl_c_reg <= wr_data;
          `PROX_CMD_LOW_LIMIT: low_limit_reg <= wr_data;
          `PROX_CMD_HIGH_LIMIT: high_limit_reg <= wr_data;
          `PROX_CMD_OFFSET: offset_reg <= wr_data;
          default: ctrl_a_reg <= ctrl_a_reg;
        endcase
      end
      // Completion clears the trigger unless software rewrites it in that cycle
      if (meas_done && !(wr_strobe && cmd_reg == `PROX_CMD_CTRL_C)) begin
        ctrl_c_reg[`PROX_BIT_TRIGGER] <= 1'b0;
      end
    end
  end

  wire power_on = ctrl_a_reg[`PROX_BIT_POWER];
  wire force_mode = ctrl_c_reg[`PROX_BIT_FORCE_MODE];
  wire [1:0] fast_sel = ctrl_c_reg[`PROX_BIT_FAST_LO+1:`PROX_BIT_FAST_LO];
  wire [1:0] interval_sel = ctrl_b_reg[`PROX_BIT_INTERVAL_LO+1:`PROX_BIT_INTERVAL_LO];
  // Interval in 6.25 ms units: fast codes 1,2,4; normal 8,16,32,64
  wire [6:0] interval_units = (fast_sel != 2'b00) ? (7'h01 << (fast_sel - 2'b01)) : (7'h08 << interval_sel);
  wire [1:0] integ_sel = ctrl_b_reg[`PROX_BIT_INTEG_LO+1:`PROX_BIT_INTEG_LO];
  wire [1:0] pulse_sel = ctrl_b_reg[`PROX_BIT_PULSES_LO+1:`PROX_BIT_PULSES_LO];
  // Base pulses per emitter burst: 1..8, doubled for the 50 us base
  wire [4:0] burst_units = {1'b0, 4'h1 << integ_sel} << ctrl_b_reg[`PROX_BIT_BASE];
  wire [3:0] pulse_total = 4'h1 << pulse_sel;

  localparam MS_IDLE = 3'b001;
  localparam MS_BURST = 3'b010;
  localparam MS_DONE = 3'b100;
  reg [2:0] ms_reg;
  reg [31:0] interval_cnt_reg;
  reg [31:0] pulse_cnt_reg;
  reg [4:0] unit_cnt_reg;
  reg [3:0] burst_cnt_reg;
  wire interval_up = interval_cnt_reg >= interval_units * INTERVAL_TICK - 1;
  wire start_meas = power_on && ms_reg == MS_IDLE &&
    (force_mode ? ctrl_c_reg[`PROX_BIT_TRIGGER] : interval_up);
  assign meas_done = ms_reg == MS_DONE;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ms_reg <= MS_IDLE;
      interval_cnt_reg <= 32'h0;
      pulse_cnt_reg <= 32'h0;
      unit_cnt_reg <= 5'h0;
      burst_cnt_reg <= 4'h0;
      emitter_active <= 1'b0;
    end else begin
      if (!power_on || force_mode || interval_up) begin
        interval_cnt_reg <= 32'h0;
      end else begin
        interval_cnt_reg <= interval_cnt_reg + 32'h1;
      end
      case (ms_reg)
        MS_IDLE: begin
          if (start_meas) begin
            ms_reg <= MS_BURST;
            emitter_active <= 1'b1;
            pulse_cnt_reg <= 32'h0;
            unit_cnt_reg <= 5'h0;
            burst_cnt_reg <= 4'h0;
          end
        end
        MS_BURST: begin
          if (pulse_cnt_reg == PULSE_TICK - 1) begin
            pulse_cnt_reg <= 32'h0;
            if (unit_cnt_reg == burst_units - 5'h1) begin
              unit_cnt_reg <= 5'h0;
              if (burst_cnt_reg == pulse_total - 4'h1) begin
                emitter_active <= 1'b0;
                ms_reg <= MS_DONE;
              end else begin
                burst_cnt_reg <= burst_cnt_reg + 4'h1;
              end
            end else begin
              unit_cnt_reg <= unit_cnt_reg + 5'h1;
            end
          end else begin
            pulse_cnt_reg <= pulse_cnt_reg + 32'h1;
          end
          if (!power_on) begin
            emitter_active <= 1'b0;
            ms_reg <= MS_IDLE;
          end
        end
        MS_DONE: ms_reg <= MS_IDLE;
        default: ms_reg <= MS_IDLE;
      endcase
    end
  end

  // Result: offset subtracted, floored at zero, clipped to 12 bits in normal range
  wire [16:0] diff = {1'b0, raw_count} - {5'h00, offset_reg[11:0]};
  wire [15:0] net_count = diff[16] ? 16'h0000 : diff[15:0];
  wire [15:0] shaped = ctrl_a_reg[`PROX_BIT_WIDE] ? net_count :
    ((net_count > 16'h0fff) ? 16'h0fff : net_count);
  wire above = shaped > high_limit_reg;
  wire below = shaped < low_limit_reg;
  wire [1:0] irq_mode = ctrl_a_reg[`PROX_BIT_MODE_LO+1:`PROX_BIT_MODE_LO];
  wire [1:0] pers_sel = ctrl_a_reg[`PROX_BIT_PERS_LO+1:`PROX_BIT_PERS_LO];
  reg [1:0] high_run_reg, low_run_reg;
  reg level_reg;
  // Adaptive persistence: after a high event, a single crossing retriggers
  wire [1:0] need = (ctrl_a_reg[`PROX_BIT_ADAPT] && level_reg) ? 2'b00 : pers_sel;
  wire high_hit = above && high_run_reg >= need;
  wire low_hit = below && low_run_reg >= need;
  wire flags_read = st_reg == ST_TXACK && scl_fall && read_reg && cmd_reg == `PROX_CMD_FLAGS && byte_reg == 2'b01;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      result_reg <= 16'h0000;
      flags_reg <= 16'h0000;
      high_run_reg <= 2'b00;
      low_run_reg <= 2'b00;
      level_reg <= 1'b0;
    end else begin
      // A read of the flag word clears it; a new event in that cycle still sets
      if (flags_read) begin
        flags_reg <= 16'h0000;
      end
      if (meas_done) begin
        result_reg <= shaped;
        high_run_reg <= above ? ((high_run_reg == 2'b11) ? 2'b11 : high_run_reg + 2'b01) : 2'b00;
        low_run_reg <= below ? ((low_run_reg == 2'b11) ? 2'b11 : low_run_reg + 2'b01) : 2'b00;
        if (irq_mode != 2'b00) begin
          if (high_hit) begin
            flags_reg[`PROX_FLAG_HIGH] <= 1'b1;
            level_reg <= 1'b1;
          end
          if (low_hit) begin
            flags_reg[`PROX_FLAG_LOW] <= 1'b1;
            if (irq_mode == 2'b01) begin
              level_reg <= 1'b0;
            end
          end
        end
      end
      if (sun_event && ctrl_a_reg[`PROX_BIT_SUN_IRQ]) begin
        flags_reg[`PROX_FLAG_SUN] <= 1'b1;
      end
    end
  end

  // Level mode follows the near/far state; event mode follows pending flags
  assign irq_n_oe = (irq_mode == 2'b01) ? level_reg :
    ((irq_mode == 2'b11) & (|flags_reg)) | flags_reg[`PROX_FLAG_SUN];

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      sensor_power_on <= 1'b0;
      internal_calib_enable <= 1'b0;
      converter_gain_select <= 1'b0;
      converter_sensitivity_select <= 1'b0;
      crosstalk_cancel_enable <= 1'b0;
      emitter_current_select <= 3'b000;
      sun_cancel_enable <= 1'b0;
    end else begin
      sensor_power_on <= power_on;
      internal_calib_enable <= ctrl_a_reg[`PROX_BIT_CALIB];
      converter_gain_select <= ctrl_b_reg[`PROX_BIT_GAIN];
      converter_sensitivity_select <= ctrl_b_reg[`PROX_BIT_SENS];
      crosstalk_cancel_enable <= ctrl_b_reg[`PROX_BIT_XTALK];
      emitter_current_select <= ctrl_b_reg[`PROX_BIT_CURRENT_LO+2:`PROX_BIT_CURRENT_LO];
      sun_cancel_enable <= &ctrl_c_reg[`PROX_BIT_SUN_CANCEL+2:`PROX_BIT_SUN_CANCEL];
    end
  end
endmodule

// >>> prox_regs_chk.sv
// Port-level checks on the proximity register bank
`timescale 1ns/100ps
module prox_regs_chk (
  input wire clk,
  input wire rst,
  input wire pin5_in,
  input wire pin5_oe,
  input wire pin6_in,
  input wire pin6_oe,
  input wire irq_n_oe,
  input wire sun_event,
  input wire sensor_power_on,
  input wire internal_calib_enable,
  input wire converter_gain_select,
  input wire converter_sensitivity_select,
  input wire crosstalk_cancel_enable,
  input wire [2:0] emitter_current_select,
  input wire sun_cancel_enable,
  input wire emitter_active
);
  wire [8:0] cfg = {sensor_power_on, internal_calib_enable, converter_gain_select, converter_sensitivity_select,
    crosstalk_cancel_enable, emitter_current_select, sun_cancel_enable};
  logic [9:0] calm_cnt;
  // The interrupt pin may only move soon after a measurement, a sun event or bus activity
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      calm_cnt <= 10'h3ff;
    end else if (emitter_active || sun_event || !pin5_in || !pin6_in) begin
      calm_cnt <= 10'h000;
    end else if (calm_cnt != 10'h3ff) begin
      calm_cnt <= calm_cnt + 10'h001;
    end
  end
  default clocking dc @(posedge clk); endclocking
  default disable iff (rst);
  out_reset_a: assert property ($fell(rst) |-> (cfg == 9'h000 && !emitter_active)[*3])
    else $error("field outputs not at default after reset");
  pin_reset_a: assert property ($fell(rst) |-> (!pin5_oe && !pin6_oe && !irq_n_oe)[*3])
    else $error("pins driven after reset");
  one_pin_a: assert property (!(pin5_oe && pin6_oe))
    else $error("both bus pins driven");
  data6_move_a: assert property (($rose(pin6_oe) || $fell(pin6_oe)) |-> !pin5_in)
    else $error("pin6 drive moved while clock high");
  data5_move_a: assert property (($rose(pin5_oe) || $fell(pin5_oe)) |-> !pin6_in)
    else $error("pin5 drive moved while clock high");
  cfg_commit_a: assert property ($changed(cfg) |-> !(pin5_in && pin6_in))
    else $error("field outputs moved with the bus idle");
  emit_power_a: assert property (emitter_active |-> sensor_power_on)
    else $error("emitter active in shutdown");
  irq_cause_a: assert property ($changed(irq_n_oe) |-> calm_cnt < 10'd1000)
    else $error("interrupt pin moved without cause");
endmodule
bind prox_regs prox_regs_chk i_chk (.clk(clk), .rst(rst), .pin5_in(pin5_in), .pin5_oe(pin5_oe),
  .pin6_in(pin6_in), .pin6_oe(pin6_oe), .irq_n_oe(irq_n_oe), .sun_event(sun_event),
  .sensor_power_on(sensor_power_on), .internal_calib_enable(internal_calib_enable),
  .converter_gain_select(converter_gain_select), .converter_sensitivity_select(converter_sensitivity_select),
  .crosstalk_cancel_enable(crosstalk_cancel_enable), .emitter_current_select(emitter_current_select),
  .sun_cancel_enable(sun_cancel_enable), .emitter_active(emitter_active));

// >>> prox_host.sv
// Two-wire bus master model standing in for the host controller
`timescale 1ns/100ps
module prox_host (
  output logic scl_oe,
  output logic sda_oe,
  input wire logic scl,
  input wire logic sda
);
  localparam real Q = 31.25;
  int nacks = 0;
  initial begin
    scl_oe = 1'b0;
    sda_oe = 1'b0;
  end
  // Waiting on the clock wire honours a slave that holds it low
  task automatic put_bit(input logic b);
    sda_oe = !b;
    #Q scl_oe = 1'b0;
    wait (scl);
    #(2 * Q) scl_oe = 1'b1;
    #Q;
  endtask
  task automatic get_bit(output logic b);
    sda_oe = 1'b0;
    #Q scl_oe = 1'b0;
    wait (scl);
    #Q b = sda;
    #Q scl_oe = 1'b1;
    #Q;
  endtask
  task automatic go;
    sda_oe = 1'b0;
    #Q scl_oe = 1'b0;
    #(2 * Q) sda_oe = 1'b1;
    #(2 * Q) scl_oe = 1'b1;
    #Q;
  endtask
  task automatic halt;
    sda_oe = 1'b1;
    #Q scl_oe = 1'b0;
    #(2 * Q) sda_oe = 1'b0;
    #(2 * Q);
  endtask
  task automatic put_byte(input logic [7:0] d);
    logic a;
    for (int i = 7; i >= 0; i--) put_bit(d[i]);
    get_bit(a);
    if (a !== 1'b0) nacks++;
  endtask
  task automatic get_byte(output logic [7:0] d, input logic last);
    for (int i = 7; i >= 0; i--) get_bit(d[i]);
    put_bit(last);
  endtask
  task automatic write_word(input logic [6:0] a, input logic [7:0] c, input logic [15:0] d);
    go;
    put_byte({a, 1'b0});
    put_byte(c);
    put_byte(d[7:0]);
    put_byte(d[15:8]);
    halt;
  endtask
  task automatic read_word(input logic [6:0] a, input logic [7:0] c, output logic [15:0] d);
    go;
    put_byte({a, 1'b0});
    put_byte(c);
    go;
    put_byte({a, 1'b1});
    get_byte(d[7:0], 1'b0);
    get_byte(d[15:8], 1'b1);
    halt;
  endtask
endmodule

// >>> testbench.sv
// Self-checking bench for the proximity register bank
`timescale 1ns/100ps
`include "prox_map.vh"
module testbench;
  logic clk = 1'b0, rst = 1'b1, swap = 1'b0, sun_event = 1'b0, irq_lvl = 1'b0;
  logic [15:0] raw_count = 16'h0000, d, off;
  logic [6:0] adr = `PROX_ADDR_PRIMARY;
  logic [15:0] mdl [0:255];
  logic [15:0] masks [0:5] = '{16'h7f80, 16'h37ff, 16'hc010, 16'hffff, 16'hffff, 16'h0fff};
  logic [7:0] codes [0:8] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'hf8, 8'hf9, 8'hfa};
  int n_errors = 0, comparisons = 0, cycles = 0, run_hi = 0, run_lo = 0;
  wire pin5_oe, pin6_oe, irq_n_oe, h_scl_oe, h_sda_oe, power_on, calib, gain, sens, xtalk, sun_cancel, emit;
  wire [2:0] current;
  // Open-drain wires with pull-ups; swap routes the host clock onto pin6
  wire scl_w = !(h_scl_oe || (swap ? pin6_oe : pin5_oe));
  wire sda_w = !(h_sda_oe || (swap ? pin5_oe : pin6_oe));
  wire pin5_in = swap ? sda_w : scl_w;
  wire pin6_in = swap ? scl_w : sda_w;
  always #2 clk = !clk;
  prox_regs #(.INTERVAL_TICK(20), .PULSE_TICK(4)) i_dut (.clk(clk), .rst(rst), .pin5_in(pin5_in),
    .pin5_oe(pin5_oe), .pin6_in(pin6_in), .pin6_oe(pin6_oe), .irq_n_oe(irq_n_oe), .raw_count(raw_count),
    .sun_event(sun_event), .sensor_power_on(power_on), .internal_calib_enable(calib),
    .converter_gain_select(gain), .converter_sensitivity_select(sens), .crosstalk_cancel_enable(xtalk),
    .emitter_current_select(current), .sun_cancel_enable(sun_cancel), .emitter_active(emit));
  prox_host i_host (.scl_oe(h_scl_oe), .sda_oe(h_sda_oe), .scl(scl_w), .sda(sda_w));
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    comparisons++;
    if (seen !== want) begin
      n_errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic close_out;
    $display("Comparisons %0d, mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  function automatic logic irq_exp();
    case (mdl[0][9:8])
      2'b01: return irq_lvl;
      2'b11: return mdl[8'hf9] != 16'h0000;
      default: return 1'b0;
    endcase
  endfunction
  task automatic wr(input logic [7:0] c, input logic [15:0] v);
    i_host.write_word(adr, c, v);
    if (c <= 8'h05) mdl[c] = v;
  endtask
  task automatic rd(input logic [7:0] c);
    logic [15:0] v;
    i_host.read_word(adr, c, v);
    check(c == 8'hf9 ? v & 16'hff00 : v, mdl[c]);
    if (c == 8'hf9) begin
      mdl[c] = 16'h0000;
      check(16'(irq_n_oe), 16'(irq_exp()));
    end
  endtask
  task automatic measure(input logic [15:0] raw);
    logic [15:0] v;
    int r;
    int need;
    @(negedge clk) raw_count = raw;
    wr(8'h02, 16'h0030);
    mdl[2] = 16'h0010;
    v = 16'h0020;
    for (int i = 0; i < 10 && v[5]; i++) i_host.read_word(adr, 8'h02, v);
    check(v, mdl[2]);
    r = raw > mdl[5] ? raw - mdl[5] : 0;
    if (!mdl[0][14] && r > 'hfff) r = 'hfff;
    mdl[8'hf8] = r[15:0];
    need = (mdl[0][12] && irq_lvl) ? 1 : mdl[0][11:10] + 1;
    run_hi = r > mdl[4] ? run_hi + 1 : 0;
    run_lo = r < mdl[3] ? run_lo + 1 : 0;
    if (run_hi >= need) begin
      mdl[8'hf9][`PROX_FLAG_HIGH] = 1'b1;
      irq_lvl = 1'b1;
    end
    if (run_lo >= need) begin
      mdl[8'hf9][`PROX_FLAG_LOW] = 1'b1;
      if (mdl[0][9:8] == 2'b01) irq_lvl = 1'b0;
    end
    rd(8'hf8);
    check(16'(irq_n_oe), 16'(irq_exp()));
  endtask
  initial begin
    void'($urandom(51177));
    for (int i = 0; i < 256; i++) mdl[i] = 16'h0000;
    mdl[8'hfa] = {`PROX_IDENT_HIGH, `PROX_IDENT_LOW_PRIMARY};
    repeat (10) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    foreach (codes[i]) rd(codes[i]);
    // Reserved bits stay at zero; sun cancel field is all clear or all set
    for (int c = 0; c < 6; c++) begin
      d = 16'($urandom) & masks[c];
      if (c == 2 && $urandom % 2 == 1) d = d | 16'h1c00;
      wr(8'(c), d);
      rd(8'(c));
    end
    @(negedge clk);
    check(16'({power_on, calib, gain, sens, xtalk, current, sun_cancel}), 16'({mdl[0][0], mdl[0][7], mdl[1][0],
      mdl[1][13], mdl[1][12], mdl[1][10:8], mdl[2][10]}));
    wr(8'hf8, 16'hffff);
    wr(8'h07, 16'h1234);
    rd(8'hf8);
    off = 16'($urandom) & 16'h00ff;
    wr(8'h02, 16'h0010);
    wr(8'h05, off);
    wr(8'h04, 16'h0800);
    wr(8'h03, 16'h0100);
    wr(8'h00, 16'h0101);
    measure(off + 16'h0f00);
    rd(8'hf9);
    rd(8'hf9);
    measure(off + 16'h0050);
    measure(16'h0000);
    rd(8'hf9);
    wr(8'h00, 16'h0701);
    measure(off + 16'h0f00);
    rd(8'hf9);
    measure(off + 16'h0f00);
    rd(8'hf9);
    wr(8'h00, 16'h4301);
    measure(16'hffff);
    rd(8'hf9);
    for (int en = 1; en >= 0; en--) begin
      wr(8'h00, en == 1 ? 16'h2001 : 16'h0001);
      @(negedge clk) sun_event = 1'b1;
      @(negedge clk) sun_event = 1'b0;
      mdl[8'hf9][`PROX_FLAG_SUN] = en[0];
      rd(8'hf9);
    end
    // After a high event a single crossing retriggers although two are asked for
    wr(8'h00, 16'h1501);
    measure(off + 16'h0400);
    measure(off + 16'h0f00);
    rd(8'hf9);
    @(negedge clk) rst = 1'b1;
    swap = 1'b1;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    for (int i = 0; i < 6; i++) mdl[i] = 16'h0000;
    repeat (4) @(negedge clk);
    adr = `PROX_ADDR_SWAPPED;
    mdl[8'hfa][7:0] = `PROX_IDENT_LOW_SWAPPED;
    rd(8'hfa);
    i_host.write_word(`PROX_ADDR_PRIMARY, 8'h00, 16'h0080);
    rd(8'h00);
    check(16'(i_host.nacks), 16'h0004);
    close_out;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 100000) begin
      n_errors++;
      close_out;
    end
  end
endmodule
